//--- rtl/rxfac_top.sv
// receive frame accept configuration register and frame accept filter
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps

module rxfac_top
#(
   // frame length limits in bytes; a larger receive fifo could raise the long limit
   parameter logic [11:0] MIN_LEN = rxfac_pkg::MIN_FRAME,
   parameter logic [11:0] STD_MAX_LEN = rxfac_pkg::STD_MAX,
   parameter logic [11:0] STD_CUT_LEN = rxfac_pkg::STD_CUT,
   parameter logic [11:0] LONG_MAX_LEN = rxfac_pkg::LONG_MAX
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire rxfac_pkg::rxfac_byte_t rxIn,
   input wire logic localTransmit,
   input wire logic [11:0] fifoLevel,
   output rxfac_pkg::rxfac_fifo_t fifoOut,
   output logic [7:0] rxMaxBurstWords,
   output logic drainStart
);

   // ----------------------------------------------------------------
   // register bus slave
   // ----------------------------------------------------------------
   logic [31:0] receiveConfig_reg;
   logic awHeld_reg;
   logic [7:0] awAddr_reg;
   logic wHeld_reg;
   logic [31:0] wData_reg;
   logic [3:0] wStrb_reg;
   logic [31:0] statusWord;
   logic [31:0] strobeMask;
   logic doWrite;

   assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
   assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;
   assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // address and data may arrive in either order; each is parked until both are in
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         awAddr_reg <= 8'h00;
         wData_reg <= 32'h0000_0000;
         wStrb_reg <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
         end
         else if (doWrite)
            awHeld_reg <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         else if (doWrite)
            wHeld_reg <= 1'b0;
      end
   end

   // byte strobes widened to a bit mask
   always_comb
   begin
      for (int i = 0; i < 4; i++)
         strobeMask[i*8 +: 8] = {8{wStrb_reg[i]}};
   end

   // configuration register; unused bits never store
   always_ff @(posedge clk)
   begin
      if (rst)
         receiveConfig_reg <= rxfac_pkg::RECEIVE_CONFIG_RESET;
      else if (doWrite && awAddr_reg == rxfac_pkg::RECEIVE_CONFIG_ADDR)
         receiveConfig_reg <= (receiveConfig_reg & ~(strobeMask & rxfac_pkg::RECEIVE_CONFIG_WMASK))
            | (wData_reg & strobeMask & rxfac_pkg::RECEIVE_CONFIG_WMASK);
   end

   // write response
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= rxfac_pkg::RESP_OKAY;
      end
      else if (doWrite)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (awAddr_reg == rxfac_pkg::RECEIVE_CONFIG_ADDR) ? rxfac_pkg::RESP_OKAY
            : rxfac_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // read channel; status register is read-only and shows filter state
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= rxfac_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         if (s_axi_araddr == rxfac_pkg::RECEIVE_CONFIG_ADDR)
         begin
            s_axi_rdata <= receiveConfig_reg;
            s_axi_rresp <= rxfac_pkg::RESP_OKAY;
         end
         else if (s_axi_araddr == rxfac_pkg::RX_STATUS_ADDR)
         begin
            s_axi_rdata <= statusWord;
            s_axi_rresp <= rxfac_pkg::RESP_OKAY;
         end
         else
         begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= rxfac_pkg::RESP_SLVERR;
         end
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // ----------------------------------------------------------------
   // configuration fields
   // ----------------------------------------------------------------
   logic acceptErroredFrames;
   logic acceptShortFrames;
   logic acceptSelfTransmit;
   logic acceptOversizeFrames;
   logic [2:0] rxMaxBurstSize;
   logic [4:0] rxDrainThreshold;

   assign acceptErroredFrames = receiveConfig_reg[rxfac_pkg::ERR_BIT];
   assign acceptShortFrames = receiveConfig_reg[rxfac_pkg::SHORT_BIT];
   assign acceptSelfTransmit = receiveConfig_reg[rxfac_pkg::SELFTX_BIT];
   assign acceptOversizeFrames = receiveConfig_reg[rxfac_pkg::OVERSIZE_BIT];
   assign rxMaxBurstSize = receiveConfig_reg[rxfac_pkg::BURST_LSB +: rxfac_pkg::BURST_W];
   assign rxDrainThreshold = receiveConfig_reg[rxfac_pkg::DRAIN_LSB +: rxfac_pkg::DRAIN_W];

   // burst decode: code 0 is the largest, otherwise a power of two
   always_ff @(posedge clk)
   begin
      if (rst)
         rxMaxBurstWords <= rxfac_pkg::BURST_MAX_WORDS;
      else if (rxMaxBurstSize == 3'h0)
         rxMaxBurstWords <= rxfac_pkg::BURST_MAX_WORDS;
      else
         rxMaxBurstWords <= 8'h01 << (rxMaxBurstSize - 3'h1);
   end

   // ----------------------------------------------------------------
   // frame filter
   // ----------------------------------------------------------------
   logic [11:0] byteCount_reg;
   logic cut_reg;
   logic errSeen_reg;
   logic txSeen_reg;
   logic frameEndSeen_reg;
   logic [11:0] cutLimit;
   logic [11:0] lenNow;
   logic byteErr;
   logic txHit;
   logic errNow;
   logic txNow;
   logic reject;
   logic tooLong;
   logic [11:0] frameLen_reg;
   logic [11:0] fullLen;

   // oversize frames are cut at a length set by the oversize bit
   assign cutLimit = acceptOversizeFrames ? LONG_MAX_LEN : STD_CUT_LEN;
   assign lenNow = byteCount_reg + 12'h001;
   // true length saturates rather than wrapping on a runaway frame
   assign fullLen = (frameLen_reg == '1) ? frameLen_reg : frameLen_reg + 12'h001;
   // collisions do not count as errors while self-transmit is accepted
   assign byteErr = rxIn.crcErr || rxIn.alignErr || (rxIn.collision && !acceptSelfTransmit);
   assign txHit = localTransmit && !acceptSelfTransmit;
   assign errNow = errSeen_reg || byteErr;
   assign txNow = txSeen_reg || txHit;
   // long flag: true length over the standard limit without oversize accept, or truncated at the long limit
   assign tooLong = acceptOversizeFrames ? cut_reg : (fullLen > STD_MAX_LEN);
   // final verdict taken on the last byte of a frame
   always_comb
   begin
      reject = 1'b0;
      if (errNow && !acceptErroredFrames)
         reject = 1'b1;
      if (lenNow < MIN_LEN && (!acceptShortFrames || errNow))
         reject = 1'b1;
      if (txNow)
         reject = 1'b1;
      if (tooLong && !acceptOversizeFrames)
         reject = 1'b1;
   end

   // stored count and cut point; the stored count stops at the cut
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         byteCount_reg <= 12'h000;
         cut_reg <= 1'b0;
      end
      else if (rxIn.valid && rxIn.last)
      begin
         byteCount_reg <= 12'h000;
         cut_reg <= 1'b0;
      end
      else if (rxIn.valid)
      begin
         if (!cut_reg)
            byteCount_reg <= lenNow;
         if (lenNow >= cutLimit)
            cut_reg <= 1'b1;
      end
   end

   // sticky error and transmit-overlap flags, cleared as each frame ends
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         errSeen_reg <= 1'b0;
         txSeen_reg <= 1'b0;
      end
      else if (rxIn.valid && rxIn.last)
      begin
         errSeen_reg <= 1'b0;
         txSeen_reg <= 1'b0;
      end
      else if (rxIn.valid)
      begin
         errSeen_reg <= errNow;
         txSeen_reg <= txNow;
      end
   end

   // true length keeps counting past the cut, so a frame that is cut but not over the limit is kept
   always_ff @(posedge clk)
   begin
      if (rst)
         frameLen_reg <= 12'h000;
      else if (rxIn.valid && rxIn.last)
         frameLen_reg <= 12'h000;
      else if (rxIn.valid)
         frameLen_reg <= fullLen;
   end

   // bytes to the fifo; bytes past the cut point other than the last are withheld
   always_ff @(posedge clk)
   begin
      if (rst)
         fifoOut <= '0;
      else
      begin
         fifoOut.valid <= rxIn.valid && (!cut_reg || rxIn.last);
         fifoOut.last <= rxIn.valid && rxIn.last;
         fifoOut.data <= rxIn.data;
         fifoOut.drop <= rxIn.valid && rxIn.last && reject;
         fifoOut.isLong <= rxIn.valid && rxIn.last && tooLong;
         fifoOut.errSeen <= rxIn.valid && rxIn.last && errNow;
      end
   end

   // ----------------------------------------------------------------
   // drain threshold
   // ----------------------------------------------------------------
   // a frame end that is not rejected arms the start even below the threshold
   always_ff @(posedge clk)
   begin
      if (rst)
         frameEndSeen_reg <= 1'b0;
      else
         frameEndSeen_reg <= rxIn.valid && rxIn.last && !reject;
   end

   logic [11:0] drainLevel;

   // threshold in 8-byte units turned into a byte level
   assign drainLevel = {4'h0, rxDrainThreshold, 3'h0};

   // threshold of zero is undefined; it simply fires at any fill
   always_ff @(posedge clk)
   begin
      if (rst)
         drainStart <= 1'b0;
      else
         drainStart <= (fifoLevel >= drainLevel) || frameEndSeen_reg;
   end

   // ----------------------------------------------------------------
   // status
   // ----------------------------------------------------------------
   // status: live per-frame state for software
   assign statusWord = {16'h0000, 1'b0, txSeen_reg, errSeen_reg, cut_reg, byteCount_reg};

endmodule

//--- include/rxfac_pkg.sv
// package for the receive frame accept configuration block
package rxfac_pkg;
   // register map
   localparam logic [7:0] RECEIVE_CONFIG_ADDR = 8'h34;
   localparam logic [7:0] RX_STATUS_ADDR = 8'h38;
   localparam logic [31:0] RECEIVE_CONFIG_RESET = 32'h0000_0002;
   // writable bits: 31, 30, 28, 27, 22-20, 5-1
   localparam logic [31:0] RECEIVE_CONFIG_WMASK = 32'hd870_003e;
   localparam int ERR_BIT = 31;
   localparam int SHORT_BIT = 30;
   localparam int SELFTX_BIT = 28;
   localparam int OVERSIZE_BIT = 27;
   localparam int BURST_LSB = 20;
   localparam int BURST_W = 3;
   // burst code zero stands for the largest burst
   localparam logic [7:0] BURST_MAX_WORDS = 8'h80;
   localparam int DRAIN_LSB = 1;
   localparam int DRAIN_W = 5;
   // frame length limits in bytes
   localparam logic [11:0] MIN_FRAME = 12'h040;
   localparam logic [11:0] STD_MAX = 12'h5ee;
   localparam logic [11:0] STD_CUT = 12'h5ea;
   localparam logic [11:0] LONG_MAX = 12'h7fe;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // per-byte receive indication from the phy side
   typedef struct packed
   {
      logic valid;
      logic last;
      logic crcErr;
      logic alignErr;
      logic collision;
      logic [7:0] data;
   } rxfac_byte_t;

   // per-byte output to the receive fifo
   typedef struct packed
   {
      logic valid;
      logic last;
      logic drop;
      logic isLong;
      logic errSeen;
      logic [7:0] data;
   } rxfac_fifo_t;
endpackage

//--- tb/rxfac_top_sva.sv
// port assertions for the receive accept block
`timescale 1ns/1ps
module rxfac_top_sva
(
   input wire logic clk,
   input wire logic rst,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire rxfac_pkg::rxfac_byte_t rxIn,
   input wire rxfac_pkg::rxfac_fifo_t fifoOut,
   input wire logic [7:0] rxMaxBurstWords
);
   // ----------
   // checks
   // ----------
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (rst);
   a_burst_onehot:
      assert property ($onehot(rxMaxBurstWords)) else $error("burst size not a power of two");
   a_reserved_zero:
      assert property (s_axi_rvalid |-> s_axi_rdata[25:23] == 3'h0) else $error("bits 25-23 read nonzero");
   a_unused_zero:
      assert property (s_axi_rvalid |-> !s_axi_rdata[29] && !s_axi_rdata[26]) else $error("bit 29 or 26 set");
   a_read_answer:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
   a_read_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
         else $error("read data not held");
   a_byte_copy:
      assert property (fifoOut.valid |-> $past(rxIn.valid) && fifoOut.data == $past(rxIn.data))
         else $error("fifo byte has no source");
   a_last_passes:
      assert property (rxIn.valid && rxIn.last |=> fifoOut.valid && fifoOut.last) else $error("frame end lost");
   a_flags_on_last:
      assert property (fifoOut.drop || fifoOut.errSeen || fifoOut.isLong |-> fifoOut.last)
         else $error("verdict off the last byte");
   a_idle_quiet:
      assert property (!rxIn.valid [*2] |=> !fifoOut.valid) else $error("output with idle input");
endmodule

bind rxfac_top rxfac_top_sva rxfac_top_sva_i (.clk(clk), .rst(rst), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .rxIn(rxIn), .fifoOut(fifoOut), .rxMaxBurstWords(rxMaxBurstWords));

//--- tb/rxfac_phy_model.sv
// phy side frame source
`timescale 1ns/1ps
module rxfac_phy_model
(
   input wire logic clk,
   output rxfac_pkg::rxfac_byte_t rxIn
);
   int seed = 32'h8acb;
   initial rxIn = '0;
   // one byte a cycle; crc and alignment marks ride on the last byte
   task automatic send(input int len, input bit crc, input bit aln, input bit col);
      for (int i = 0; i < len; i++)
      begin
         @(posedge clk);
         rxIn <= {1'b1, i == len - 1, crc && i == len - 1, aln && i == len - 1, col && i == len / 2, 8'($random(seed))};
      end
      @(posedge clk);
      // released data line flips so stale bytes never look valid
      rxIn <= {5'h00, ~rxIn.data};
   endtask
endmodule

//--- tb/test_rx_frame_accept_config.sv
// self-checking bench for the receive accept block
`timescale 1ns/1ps
module test_rx_frame_accept_config;
   logic clk = 1'b0, rst = 1'b1, awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
   logic awReady, wReady, bValid, arReady, rValid, drainStart, localTransmit = 1'b0;
   logic [7:0] awAddr = 8'h00, arAddr = 8'h00, rxMaxBurstWords;
   logic [31:0] wData = 32'h0, rData;
   logic [1:0] bResp, rResp;
   logic [11:0] fifoLevel = 12'h000;
   rxfac_pkg::rxfac_byte_t rxIn;
   rxfac_pkg::rxfac_fifo_t fifoOut;
   int errors = 0, nTests = 0, cyc = 0, nBytes = 0, seed = 32'h8acb;
   int expQ[$];
   int cases[19] = '{32'h64, 32'h80064, 32'h80080064, 32'h40064, 32'h28, 32'h40000028, 32'hc0080028,
      32'h10020064, 32'h20064, 32'h10064, 32'h10010064, 32'h640, 32'h8000640, 32'h8000834, 32'h5ee,
      32'h5ef, 32'h80007fe, 32'h3f, 32'h40};
   always #2.5 clk = ~clk;
   rxfac_top rxfac_top_i (.clk(clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
      .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
      .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .rxIn(rxIn),
      .localTransmit(localTransmit), .fifoLevel(fifoLevel), .fifoOut(fifoOut),
      .rxMaxBurstWords(rxMaxBurstWords), .drainStart(drainStart));
   rxfac_phy_model rxfac_phy_model_i (.clk(clk), .rxIn(rxIn));
   // ----------
   // helpers
   // ----------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      nTests++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", nTests, errors);
      if (errors == 0 && nTests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge clk);
      {awAddr, wData, awValid, wValid, bReady} <= {a, d, 3'h7};
      do
      begin
         @(posedge clk);
         if (awReady) awValid <= 1'b0;
         if (wReady) wValid <= 1'b0;
      end while (!bValid);
      bReady <= 1'b0;
      check(bResp, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge clk);
      {arAddr, arValid, rReady} <= {a, 2'h3};
      do
      begin
         @(posedge clk);
         if (arReady) arValid <= 1'b0;
      end while (!rValid);
      rReady <= 1'b0;
      check(rData, d);
      check(rResp, r);
   endtask
   // frame verdicts are judged on the last byte; the byte count covers the cut
   always @(posedge clk)
      if (fifoOut.valid)
      begin
         nBytes++;
         if (fifoOut.last)
         begin
            automatic int e = expQ.pop_front();
            check(nBytes, e[15:0]);
            check(fifoOut.drop, e[16]);
            if (!e[16]) check(fifoOut.errSeen, e[17]);
            if (e[19]) check(fifoOut.isLong, e[18]);
            nBytes = 0;
         end
      end
   // hang guard, well beyond the expected run length
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 80000)
      begin
         errors++;
         conclude();
      end
   end
   // ----------
   // main sequence
   // ----------
   initial
   begin
      automatic int c, len, err, drop;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(rxfac_pkg::RECEIVE_CONFIG_ADDR, rxfac_pkg::RECEIVE_CONFIG_RESET, rxfac_pkg::RESP_OKAY);
      rd(rxfac_pkg::RX_STATUS_ADDR, 32'h0000_0000, rxfac_pkg::RESP_OKAY);
      check(rxMaxBurstWords, 128);
      for (int i = 0; i < 4; i++)
      begin
         c = $random(seed);
         wr(rxfac_pkg::RECEIVE_CONFIG_ADDR, c, rxfac_pkg::RESP_OKAY);
         rd(rxfac_pkg::RECEIVE_CONFIG_ADDR, c & rxfac_pkg::RECEIVE_CONFIG_WMASK, rxfac_pkg::RESP_OKAY);
      end
      wr(8'h40, 32'hffffffff, rxfac_pkg::RESP_SLVERR);
      rd(8'h40, 32'h0, rxfac_pkg::RESP_SLVERR);
      $display("register test done");
      for (int k = 0; k < 8; k++)
      begin
         wr(rxfac_pkg::RECEIVE_CONFIG_ADDR, (k << 20) | ((k + 1) << 1), rxfac_pkg::RESP_OKAY);
         fifoLevel <= 12'((k + 1) * 8 - 1);
         repeat (2) @(posedge clk);
         check(rxMaxBurstWords, k == 0 ? 128 : 1 << (k - 1));
         check(drainStart, 1'b0);
         fifoLevel <= 12'((k + 1) * 8);
         repeat (2) @(posedge clk);
         check(drainStart, 1'b1);
      end
      $display("burst and drain test done");
      for (int i = 0; i < 27; i++)
      begin
         c = i < 19 ? cases[i] : ($random(seed) & 32'hd80f0000) | (20 + {$random(seed)} % 2100);
         len = c[15:0];
         err = c[19] | c[18] | (c[17] & !c[28]);
         drop = (err && !c[31]) || (len < 64 && !(c[30] && !err)) || (c[16] && !c[28]) || (len > 1518 && !c[27]);
         expQ.push_back({c[27], c[27] && len > 2046, err[0], drop[0],
            16'(len > (c[27] ? 2046 : 1514) ? (c[27] ? 2047 : 1515) : len)});
         // self-transmit accept goes in with the rest of the word before any overlap
         wr(rxfac_pkg::RECEIVE_CONFIG_ADDR, (c & 32'hd8000000) | 32'h2, rxfac_pkg::RESP_OKAY);
         localTransmit <= c[16];
         rxfac_phy_model_i.send(len, c[19], c[18], c[17]);
         localTransmit <= 1'b0;
         $display("frame test %0d done", i);
      end
      repeat (4) @(posedge clk);
      check(expQ.size(), 0);
      conclude();
   end
endmodule
